// File: cbe_map.svh
`ifndef CBE_MAP_SVH
`define CBE_MAP_SVH

// ---------------------------------------------------------------------------
// register offsets and fields
// ---------------------------------------------------------------------------
`define CBE_ADDR_W          4
`define CBE_REG_OUT_EN      4'h0
`define CBE_REG_PLL_CTRL    4'h1
`define CBE_REG_STATUS      4'h2
`define CBE_REG_STRAP       4'h3
`define CBE_OUT_EN_RESET    8'hFF
`define CBE_PLL_CTRL_RESET  3'h3
`define CBE_NUM_OUT         8

// ---------------------------------------------------------------------------
// bandwidth select codes
// ---------------------------------------------------------------------------
`define CBE_BW_LOW          2'h0
`define CBE_BW_BYPASS       2'h1
`define CBE_BW_HIGH         2'h3

// ---------------------------------------------------------------------------
// timing
// ---------------------------------------------------------------------------
`define CBE_CLK_MHZ         200
`define CBE_SETTLE_MIN_US   100
`define CBE_SETTLE_CYC      (`CBE_SETTLE_MIN_US * `CBE_CLK_MHZ)
`define CBE_POWERUP_MAX_US  1800
`define CBE_POWERUP_CYC     (`CBE_POWERUP_MAX_US * `CBE_CLK_MHZ)
`define CBE_CNT_W           19

`endif

// File: cbe_pkg.sv
package cbe_pkg;
    typedef enum logic [3:0] {
        CBE_ST_OFF    = 4'b0001,
        CBE_ST_SETTLE = 4'b0010,
        CBE_ST_WAIT   = 4'b0100,
        CBE_ST_RUN    = 4'b1000
    } cbe_state_type;
endpackage : cbe_pkg

// File: cbe_sync2.sv
`timescale 1ns/1ps
module cbe_sync2 #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_in,
    input  wire logic             reset_in,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
    } cbe_sync_type;

    cbe_sync_type state_ff;
    cbe_sync_type nxt_state;

    always_comb begin
        nxt_state.meta = async_in;
        nxt_state.sync = state_ff.meta;
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign sync_out = state_ff.sync;
endmodule : cbe_sync2

// File: cbe_out_gate.sv
`timescale 1ns/1ps
`include "cbe_map.svh"
// ---------------------------------------------------------------------------
// per-output gate, glitch free on the true leg only: enable changes only while the leg is low
// ---------------------------------------------------------------------------
module cbe_out_gate (
    input  wire logic clk_in,
    input  wire logic reset_in,
    input  wire logic ref_clk_in,
    input  wire logic run_in,
    input  wire logic tristate_in,
    output logic      diff_clock_out,
    output logic      diff_clock_out_comp,
    output logic      diff_clock_oe_n_out
);
    typedef struct packed {
        logic en;
        logic p;
        logic n;
        logic oe_n;
    } cbe_gate_type;

    cbe_gate_type state_ff;
    cbe_gate_type nxt_state;

    always_comb begin
        nxt_state = state_ff;
        // only retime the enable while the true leg is low
        if (!ref_clk_in) begin
            nxt_state.en = run_in;
        end
        nxt_state.p    = state_ff.en & ref_clk_in;
        nxt_state.n    = state_ff.en & ~ref_clk_in;
        nxt_state.oe_n = tristate_in;
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            state_ff <= 4'h1;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign diff_clock_out      = state_ff.p;
    assign diff_clock_out_comp = state_ff.n;
    assign diff_clock_oe_n_out = state_ff.oe_n;
endmodule : cbe_out_gate

// File: cbe_ctrl.sv
`timescale 1ns/1ps
`include "cbe_map.svh"
// Contract
// - eight outputs, each with own software bit and own active-low pin
// - software enables active high, reset to enabled
// - disabled output drives both legs low
// - output runs only with pin low and software bit set
// - enable pins are asynchronous and must be tolerated
// - pin falling restarts output without glitches; the code can cut the first comp-leg pulse to one cycle
// - pin rising stops output cleanly into off state; the code can cut the last comp-leg pulse to one cycle
// - strapped frequency select chosen; output frequency equals reference
// - power-good rise captures frequency select and address straps
// - after first power-good the pin becomes async power-down request
// - power-down low over two comp rises tri-states on next comp fall
// - three-level bandwidth input picks high, bypass or low bandwidth
// - after supply detect, wait 0.1 to 0.3 ms
// - second state waits for reference valid and power-good high
// - third state entered and outputs enabled only after lock
// - power-on to outputs active under 1.8 ms
// - no reference detected keeps outputs disabled
// - cleared software bit forces output off regardless of pin
// - host writes control bytes by indexed block write; the code takes one byte per reg_wr_in at reg_addr_in
module cbe_ctrl (
    input  wire logic                   clk_in,
    input  wire logic                   reset_in,
    // register port
    input  wire logic [`CBE_ADDR_W-1:0] reg_addr_in,
    input  wire logic [7:0]             reg_wdata_in,
    input  wire logic                   reg_wr_in,
    input  wire logic                   reg_rd_in,
    output logic      [7:0]             reg_rdata_out,
    // pins
    input  wire logic                   supply_ok_in,
    input  wire logic                   ref_clk_in,
    input  wire logic                   ref_valid_in,
    input  wire logic                   pll_lock_in,
    input  wire logic [7:0]             out_enable_n_in,
    input  wire logic                   power_good_down_pin_in,
    input  wire logic                   freq_select_pin_in,
    input  wire logic [1:0]             bw_select_pin_in,
    input  wire logic [1:0]             serial_address_select_in,
    // outputs
    output logic      [7:0]             diff_clock_out,
    output logic      [7:0]             diff_clock_out_comp,
    output logic      [7:0]             diff_clock_oe_n_out,
    output logic                        freq_100m_out,
    output logic      [1:0]             pll_mode_out,
    output logic      [1:0]             serial_address_out,
    output logic                        power_save_out,
    output logic      [3:0]             state_out
);
    import cbe_pkg::*;

    // -----------------------------------------------------------------------
    // state
    // -----------------------------------------------------------------------
    typedef struct packed {
        cbe_state_type          fsm;
        logic [`CBE_CNT_W-1:0]  cnt;
        logic [7:0]             sw_en;
        logic                   pll_sw;
        logic [1:0]             pll_sw_mode;
        logic                   straps_taken;
        logic                   freq_100m;
        logic [1:0]             pll_strap;
        logic [1:0]             sa;
        logic                   pg_prev;
        logic                   comp_prev;
        logic [1:0]             pd_rises;
        logic                   tristate;
        logic [7:0]             rdata;
        logic [1:0]             pll_mode;
    } cbe_ctrl_type;

    cbe_ctrl_type state_ff;
    cbe_ctrl_type nxt_state;

    logic [7:0] oe_n_sync;
    logic [3:0] misc_sync;
    logic [4:0] strap_sync;
    logic [7:0] run;
    logic       pg;
    logic       ref_ok;
    logic       lock;
    logic       sup_ok;

    // -----------------------------------------------------------------------
    // input synchronisers
    // -----------------------------------------------------------------------
    cbe_sync2 #(.WIDTH(8)) u_sync_oe (
        .clk_in   (clk_in),
        .reset_in (reset_in),
        .async_in (out_enable_n_in),
        .sync_out (oe_n_sync)
    );

    cbe_sync2 #(.WIDTH(4)) u_sync_misc (
        .clk_in   (clk_in),
        .reset_in (reset_in),
        .async_in ({supply_ok_in, ref_valid_in, pll_lock_in, power_good_down_pin_in}),
        .sync_out (misc_sync)
    );

    cbe_sync2 #(.WIDTH(5)) u_sync_strap (
        .clk_in   (clk_in),
        .reset_in (reset_in),
        .async_in ({freq_select_pin_in, bw_select_pin_in, serial_address_select_in}),
        .sync_out (strap_sync)
    );

    assign sup_ok = misc_sync[3];
    assign ref_ok = misc_sync[2];
    assign lock   = misc_sync[1];
    assign pg     = misc_sync[0];

    // -----------------------------------------------------------------------
    // next state
    // -----------------------------------------------------------------------
    always_comb begin
        nxt_state           = state_ff;
        nxt_state.pg_prev   = pg;
        nxt_state.comp_prev = ~ref_clk_in;

        // strap capture on first power-good rise
        if (pg && !state_ff.pg_prev && !state_ff.straps_taken) begin
            nxt_state.straps_taken = 1'b1;
            nxt_state.freq_100m    = strap_sync[4];
            nxt_state.pll_strap    = strap_sync[3:2];
            nxt_state.sa           = strap_sync[1:0];
        end

        // power-down: two comp-leg rises with pin low, then tri-state on fall
        if (state_ff.straps_taken && !pg) begin
            if (~ref_clk_in && !state_ff.comp_prev && state_ff.pd_rises != 2'h2) begin
                nxt_state.pd_rises = state_ff.pd_rises + 2'h1;
            end
            if (ref_clk_in && state_ff.comp_prev && state_ff.pd_rises == 2'h2) begin
                nxt_state.tristate = 1'b1;
            end
        end else if (pg) begin
            nxt_state.pd_rises = 2'h0;
            if (state_ff.fsm == CBE_ST_RUN) begin
                nxt_state.tristate = 1'b0;
            end
        end

        // power-up sequencer
        case (state_ff.fsm)
            CBE_ST_OFF: begin
                nxt_state.tristate = 1'b1;
                if (sup_ok) begin
                    nxt_state.fsm = CBE_ST_SETTLE;
                    nxt_state.cnt = '0;
                end
            end
            CBE_ST_SETTLE: begin
                nxt_state.cnt = state_ff.cnt + 1'b1;
                if (state_ff.cnt == `CBE_CNT_W'(`CBE_SETTLE_CYC - 1)) begin
                    nxt_state.fsm = CBE_ST_WAIT;
                end
            end
            CBE_ST_WAIT: begin
                if (state_ff.cnt != `CBE_CNT_W'(`CBE_POWERUP_CYC - 1)) begin
                    nxt_state.cnt = state_ff.cnt + 1'b1;
                end
                // straps settle at least one cycle before run so they never move in run
                if (ref_ok && pg && lock && state_ff.straps_taken) begin
                    nxt_state.fsm      = CBE_ST_RUN;
                    nxt_state.tristate = 1'b0;
                end
            end
            CBE_ST_RUN: begin
                if (!ref_ok || !lock) begin
                    nxt_state.fsm = CBE_ST_WAIT;
                end
            end
            default: begin
                nxt_state.fsm = CBE_ST_OFF;
            end
        endcase
        if (!sup_ok) begin
            nxt_state.fsm = CBE_ST_OFF;
        end

        // effective pll mode
        nxt_state.pll_mode = state_ff.pll_sw ? state_ff.pll_sw_mode
                                             : state_ff.pll_strap;

        // register writes
        if (reg_wr_in) begin
            case (reg_addr_in)
                `CBE_REG_OUT_EN: nxt_state.sw_en = reg_wdata_in;
                `CBE_REG_PLL_CTRL: begin
                    nxt_state.pll_sw      = reg_wdata_in[2];
                    nxt_state.pll_sw_mode = reg_wdata_in[1:0];
                end
                default: begin
                end
            endcase
        end

        // register reads
        nxt_state.rdata = 8'h00;
        if (reg_rd_in) begin
            case (reg_addr_in)
                `CBE_REG_OUT_EN:   nxt_state.rdata = state_ff.sw_en;
                `CBE_REG_PLL_CTRL: nxt_state.rdata = {5'h00, state_ff.pll_sw,
                                                      state_ff.pll_sw_mode};
                `CBE_REG_STATUS:   nxt_state.rdata = {state_ff.tristate, pg,
                                                      lock, ref_ok, state_ff.fsm};
                `CBE_REG_STRAP:    nxt_state.rdata = {2'h0, state_ff.straps_taken,
                                                      state_ff.freq_100m,
                                                      state_ff.pll_strap, state_ff.sa};
                default:           nxt_state.rdata = 8'h00;
            endcase
        end
    end

    // -----------------------------------------------------------------------
    // registers
    // -----------------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            state_ff              <= '0;
            state_ff.fsm          <= CBE_ST_OFF;
            state_ff.sw_en        <= `CBE_OUT_EN_RESET;
            state_ff.pll_sw_mode  <= 2'(`CBE_PLL_CTRL_RESET);
            state_ff.pll_strap    <= `CBE_BW_HIGH;
            state_ff.pll_mode     <= `CBE_BW_HIGH;
            state_ff.tristate     <= 1'b1;
            state_ff.freq_100m    <= 1'b1;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // -----------------------------------------------------------------------
    // output gates
    // -----------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < `CBE_NUM_OUT; gi++) begin : g_out
            assign run[gi] = ~oe_n_sync[gi] & state_ff.sw_en[gi] &
                             (state_ff.fsm == CBE_ST_RUN) & ~state_ff.tristate;
            cbe_out_gate u_gate (
                .clk_in              (clk_in),
                .reset_in            (reset_in),
                .ref_clk_in          (ref_clk_in),
                .run_in              (run[gi]),
                .tristate_in         (state_ff.tristate),
                .diff_clock_out      (diff_clock_out[gi]),
                .diff_clock_out_comp (diff_clock_out_comp[gi]),
                .diff_clock_oe_n_out (diff_clock_oe_n_out[gi])
            );
        end
    endgenerate

    assign reg_rdata_out      = state_ff.rdata;
    assign freq_100m_out      = state_ff.freq_100m;
    assign pll_mode_out       = state_ff.pll_mode;
    assign serial_address_out = state_ff.sa;
    assign power_save_out     = state_ff.tristate;
    assign state_out          = state_ff.fsm;
endmodule : cbe_ctrl

// File: cbe_ctrl_assertions.sv
`timescale 1ns/1ps
module cbe_ctrl_chk
    import cbe_pkg::*;
(
    input wire logic       clk_in,
    input wire logic       reset_in,
    input wire logic       pll_lock_in,
    input wire logic [7:0] out_enable_n_in,
    input wire logic       power_good_down_pin_in,
    input wire logic [7:0] diff_clock_out,
    input wire logic [7:0] diff_clock_out_comp,
    input wire logic [7:0] diff_clock_oe_n_out,
    input wire logic       freq_100m_out,
    input wire logic [1:0] serial_address_out,
    input wire logic       power_save_out,
    input wire logic [3:0] state_out
);
    // ------------------------------------------------------------
    // helper logic
    // ------------------------------------------------------------
    logic [7:0]  diff_q_ff;
    logic [7:0]  rise_v;
    logic [16:0] settle_ff;
    always_ff @(posedge clk_in) begin
        diff_q_ff <= diff_clock_out;
        settle_ff <= (state_out == 4'h2) ? settle_ff + 17'h1 : 17'h0;
    end
    assign rise_v = diff_clock_out & ~diff_q_ff;
    default clocking @(posedge clk_in); endclocking
    default disable iff (reset_in);
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    property p_legs_apart;
        (diff_clock_out & diff_clock_out_comp) == 8'h00;
    endproperty
    a_legs_apart: assert property (p_legs_apart)
        else $error("both legs of a pair high");
    property p_pin_off;
        $stable(out_enable_n_in)[*8] |->
            ((diff_clock_out | diff_clock_out_comp) & out_enable_n_in) == 8'h00;
    endproperty
    a_pin_off: assert property (p_pin_off)
        else $error("output runs with its pin high");
    property p_no_runt;
        rise_v != 8'h00 |=> power_save_out || (diff_clock_out & $past(rise_v)) == $past(rise_v);
    endproperty
    a_no_runt: assert property (p_no_runt)
        else $error("one cycle pulse on an output");
    property p_pd_cause;
        $rose(power_save_out) |-> !$past(power_good_down_pin_in, 3);
    endproperty
    a_pd_cause: assert property (p_pd_cause)
        else $error("power save without power-down request");
    property p_pd_tri;
        power_save_out[*2] |-> diff_clock_oe_n_out == 8'hFF;
    endproperty
    a_pd_tri: assert property (p_pd_tri)
        else $error("outputs driven in power save");
    property p_run_lock;
        $rose(state_out[3]) |-> $past(pll_lock_in) && $past(state_out) == 4'h4;
    endproperty
    a_run_lock: assert property (p_run_lock)
        else $error("run entered without lock");
    property p_settle;
        (settle_ff != 17'h0 && state_out == 4'h4) |-> settle_ff >= 17'h4E1E && settle_ff <= 17'hEA60;
    endproperty
    a_settle: assert property (p_settle)
        else $error("settle delay out of range");
    property p_straps;
        state_out == 4'h8 |-> $stable(serial_address_out) && $stable(freq_100m_out);
    endproperty
    a_straps: assert property (p_straps)
        else $error("captured strap changed");
    property p_off;
        (state_out != 4'h8)[*8] |-> (diff_clock_out | diff_clock_out_comp) == 8'h00;
    endproperty
    a_off: assert property (p_off)
        else $error("outputs active outside run");
endmodule : cbe_ctrl_chk

bind cbe_ctrl cbe_ctrl_chk u_chk (
    .clk_in, .reset_in, .pll_lock_in, .out_enable_n_in, .power_good_down_pin_in,
    .diff_clock_out, .diff_clock_out_comp, .diff_clock_oe_n_out, .freq_100m_out,
    .serial_address_out, .power_save_out, .state_out
);

// File: cbe_ref_src.sv
`timescale 1ns/1ps
module cbe_ref_src #(
    parameter int LOCK_CYC = 16
) (
    input  wire logic clk_in,
    input  wire logic reset_in,
    input  wire logic run_in,
    input  wire logic power_down_n_in,
    output logic      ref_clk_out,
    output logic      ref_valid_out,
    output logic      pll_lock_out
);
    // ------------------------------------------------------------
    // reference source: clk / 4, lock after LOCK_CYC cycles
    // ------------------------------------------------------------
    logic       on_ff;
    logic [1:0] div_ff;
    logic [7:0] lock_ff;
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            on_ff   <= 1'b0;
            div_ff  <= 2'h0;
            lock_ff <= 8'h00;
        end else begin
            // stops only once power-down is asserted while run_in is low
            on_ff  <= run_in | (on_ff & power_down_n_in);
            div_ff <= on_ff ? div_ff + 2'h1 : 2'h0;
            if (!on_ff) begin
                lock_ff <= 8'h00;
            end else if (lock_ff != LOCK_CYC[7:0]) begin
                lock_ff <= lock_ff + 8'h01;
            end
        end
    end
    assign ref_clk_out   = div_ff[1];
    assign ref_valid_out = on_ff;
    assign pll_lock_out  = (lock_ff == LOCK_CYC[7:0]);
endmodule : cbe_ref_src

// File: tb_cbe_ctrl.sv
`timescale 1ns/1ps
`include "cbe_map.svh"
module tb_cbe_ctrl;
    import cbe_pkg::*;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic       clk_in = 1'b0;
    logic       reset_in = 1'b1;
    logic [3:0] reg_addr_in = 4'h0;
    logic [7:0] reg_wdata_in = 8'h00;
    logic       reg_wr_in = 1'b0;
    logic       reg_rd_in = 1'b0;
    logic [7:0] reg_rdata_out;
    logic       supply_ok_in = 1'b0;
    logic       ref_clk_in;
    logic       ref_valid_in;
    logic       pll_lock_in;
    logic [7:0] out_enable_n_in = 8'hFF;
    logic       power_good_down_pin_in = 1'b0;
    logic       freq_select_pin_in = 1'b1;
    logic [1:0] bw_select_pin_in = 2'h3;
    logic [1:0] serial_address_select_in = 2'h2;
    logic       ref_run = 1'b0;
    logic [7:0] diff_clock_out;
    logic [7:0] diff_clock_out_comp;
    logic [7:0] diff_clock_oe_n_out;
    logic       freq_100m_out;
    logic [1:0] pll_mode_out;
    logic [1:0] serial_address_out;
    logic       power_save_out;
    logic [3:0] state_out;
    logic [1:0] modes [3] = '{`CBE_BW_LOW, `CBE_BW_BYPASS, `CBE_BW_HIGH};
    int         n_errors = 0;
    int         comparisons = 0;
    int         cyc = 0;
    int         t0 = 0;

    always #2.5 clk_in = ~clk_in;

    cbe_ctrl dut (
        .clk_in, .reset_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
        .reg_rdata_out, .supply_ok_in, .ref_clk_in, .ref_valid_in, .pll_lock_in,
        .out_enable_n_in, .power_good_down_pin_in, .freq_select_pin_in,
        .bw_select_pin_in, .serial_address_select_in, .diff_clock_out,
        .diff_clock_out_comp, .diff_clock_oe_n_out, .freq_100m_out, .pll_mode_out,
        .serial_address_out, .power_save_out, .state_out
    );
    cbe_ref_src u_src (
        .clk_in, .reset_in, .run_in(ref_run), .power_down_n_in(power_good_down_pin_in),
        .ref_clk_out(ref_clk_in), .ref_valid_out(ref_valid_in), .pll_lock_out(pll_lock_in)
    );
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic results;
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : results
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s exp %0h seen %0h", what, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_in);
        reg_addr_in  <= a;
        reg_wdata_in <= d;
        reg_wr_in    <= 1'b1;
        @(posedge clk_in);
        reg_wr_in <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [7:0] e, input string what);
        @(posedge clk_in);
        reg_addr_in <= a;
        reg_rd_in   <= 1'b1;
        @(posedge clk_in);
        reg_rd_in <= 1'b0;
        #1 chk(what, reg_rdata_out, e);
    endtask : rd
    task automatic wait_st(input logic [3:0] s);
        for (int i = 0; i < 70000 && state_out !== s; i++) @(posedge clk_in);
        #1 chk("state", state_out, s);
    endtask : wait_st
    task automatic activity(input logic [7:0] e, input string what);
        logic [7:0] seen;
        seen = 8'h00;
        repeat (16) @(posedge clk_in);
        repeat (16) begin
            @(posedge clk_in);
            #1 seen = seen | diff_clock_out;
        end
        chk(what, seen, e);
    endtask : activity
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            n_errors++;
            results();
        end
    end

    initial begin
        repeat (3) @(posedge clk_in);
        reset_in <= 1'b0;
        rd(`CBE_REG_OUT_EN, `CBE_OUT_EN_RESET, "out_en");
        rd(`CBE_REG_PLL_CTRL, 8'h03, "pll_ctrl");
        rd(4'h9, 8'h00, "unmapped");
        chk("oe_n", diff_clock_oe_n_out, 8'hFF);
        $display("test reset done");
        @(posedge clk_in) supply_ok_in <= 1'b1;
        t0 = cyc;
        wait_st(4'h4);
        chk("settle", (cyc - t0) >= 20000, 1'b1);
        @(posedge clk_in) power_good_down_pin_in <= 1'b1;
        repeat (100) @(posedge clk_in);
        #1 chk("no ref", state_out, 4'h4);
        chk("no ref legs", diff_clock_out | diff_clock_out_comp, 8'h00);
        @(posedge clk_in) ref_run <= 1'b1;
        wait_st(4'h8);
        chk("lock", pll_lock_in, 1'b1);
        chk("on time", (cyc - t0) < 360000, 1'b1);
        @(posedge clk_in) freq_select_pin_in <= 1'b0;
        serial_address_select_in <= 2'h1;
        repeat (8) @(posedge clk_in);
        #1 chk("freq", freq_100m_out, 1'b1);
        chk("sa", serial_address_out, 2'h2);
        rd(`CBE_REG_STRAP, 8'h3E, "straps");
        rd(`CBE_REG_STATUS, 8'h78, "status");
        $display("test power-up done");
        @(posedge clk_in) out_enable_n_in <= 8'h5A;
        activity(8'hA5, "pin gate");
        wr(`CBE_REG_OUT_EN, 8'hFE);
        activity(8'hA4, "sw off");
        @(posedge clk_in) out_enable_n_in <= 8'h00;
        activity(8'hFE, "pin restart");
        @(posedge clk_in) out_enable_n_in <= 8'hF0;
        activity(8'h0E, "pin stop");
        wr(`CBE_REG_OUT_EN, 8'hFF);
        $display("test enables done");
        foreach (modes[i]) begin
            wr(`CBE_REG_PLL_CTRL, {6'h01, modes[i]});
            repeat (4) @(posedge clk_in);
            #1 chk("pll mode", pll_mode_out, modes[i]);
        end
        $display("test modes done");
        @(posedge clk_in) power_good_down_pin_in <= 1'b0;
        repeat (40) @(posedge clk_in);
        #1 chk("power save", power_save_out, 1'b1);
        chk("tristate", diff_clock_oe_n_out, 8'hFF);
        @(posedge clk_in) power_good_down_pin_in <= 1'b1;
        repeat (40) @(posedge clk_in);
        #1 chk("resume", power_save_out, 1'b0);
        $display("test power-down done");
        results();
    end
endmodule : tb_cbe_ctrl
